// ---- cbt_top.sv ----
// What this block does
// - idle_stop set halts the controller while the system idles
// - activity status reads 1 while active, 0 only once fully disabled
// - 5-bit data filter count, values above 10010 are invalid
// - wake-up filter bit routes bus line through a filter for wake
// - second phase segment equals field plus one quanta
// - first phase segment equals field plus one quanta
// - select bit 1 frees segment two, 0 uses max of seg1 and ipt
// - seg2 no longer than seg1, sjw no longer than seg2; auto seg2 (neither limit is enforced here)
// - sample bit chooses three samples or one at sample point
// - bit timing register writable only in configuration mode
// - bus wake-up activity sets the wake-up flag
// - any detected bus error sets the bus error flag
// - system side fault sets the system error flag
// - any receive buffer overflow sets the receive overflow flag
// - mode change flag sets when current mode differs from request
// - timestamp timer overflow sets the timer overflow flag
// - pending flags follow receive and transmit buffer interrupts
// - read-only 32-bit word, one overflow bit per receive fifo
// - timer steps every prescale plus one clocks when capture set
// - any timer write loads count and prescale and clears the prescale count
// Purpose: configuration and status side of a can controller
// Assumes: event inputs are one-cycle pulses on ref_clk; can_rx is a pin
// Notes: sticky flags clear by writing 1; hardware set wins over the clear
//
// Implementation choices: the APB register port and the address map.
module cbt_top
    import cbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic system_idle,
    input wire logic can_rx,
    input wire logic engine_busy,
    input wire logic bus_error_evt,
    input wire logic system_error_evt,
    input wire logic [31:0] fifo_overflow_evt,
    input wire logic rx_buffer_pending,
    input wire logic tx_buffer_pending,
    output logic controller_run,
    output logic triple_sample,
    output logic [4:0] data_filter_compare_count,
    output logic data_filter_valid,
    output logic [3:0] phase_segment_one_tq,
    output logic [3:0] phase_segment_two_tq,
    output logic [3:0] propagation_tq,
    output logic [2:0] sync_jump_tq,
    output logic [5:0] baud_prescaler,
    output logic [5:0] bit_time_tq,
    output logic [15:0] timestamp_count,
    output logic wakeup_pulse,
    output logic can_irq
);
    import cbt_pkg::*;

    logic rx_meta_reg, rx_sync_reg, rx_prev_reg, wake_low_reg;
    logic [WAKE_FILT_LEN-1:0] rx_hist_reg;
    logic on_reg, idle_stop_reg, cap_reg, active_reg;
    logic [2:0] current_operating_mode_reg, requested_operating_mode_reg;
    logic [4:0] data_filter_compare_count_reg;
    logic [31:0] cfg_reg;
    logic [15:0] flags_reg, enables_reg;
    logic [31:0] ovf_reg;
    logic [15:0] ts_reg, tspre_reg, precnt_reg;
    logic [3:0] off_cnt_reg;
    logic [31:0] rdata_next;
    logic wr, rd_ok, ts_wrap, wake_evt, mode_evt, filt_low;
    logic tmr_wr;
    logic [3:0] seg1_tq, seg2_free;

    assign wr = psel && penable && pwrite;
    assign tmr_wr = wr && (paddr == ADDR_TMR);
    assign pready = 1'b1;
    assign rd_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_CFG) ||
        (paddr == ADDR_INT) || (paddr == ADDR_OVF) || (paddr == ADDR_TMR);
    assign pslverr = psel && penable && !rd_ok;

    // can_rx is async: two flops before anything looks at it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // sample history for the wake-up filter, idles recessive after reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_hist_reg <= '1;
            wake_low_reg <= 1'b0;
        end else begin
            rx_hist_reg <= {rx_hist_reg[WAKE_FILT_LEN-2:0], rx_sync_reg};
            wake_low_reg <= filt_low;
        end
    end

    // filter rejects short glitches so noise does not wake the node
    assign filt_low = (rx_hist_reg == '0);
    always_comb begin
        if (cfg_reg[CFG_WAKEUP_LINE_FILTER_ENABLE]) begin
            // one event on entry into a long enough dominant run
            wake_evt = filt_low && !wake_low_reg;
        end else begin
            wake_evt = rx_prev_reg && !rx_sync_reg;
        end
    end
    assign wakeup_pulse = wake_evt && (current_operating_mode_reg != MODE_CONFIG);

    // control word fields written by software
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            on_reg <= 1'b0;
            idle_stop_reg <= 1'b0;
            cap_reg <= 1'b0;
            data_filter_compare_count_reg <= 5'h00;
            requested_operating_mode_reg <= MODE_RESET_VAL;
        end else if (wr && paddr == ADDR_CTRL) begin
            on_reg <= pwdata[CTRL_ON];
            idle_stop_reg <= pwdata[CTRL_IDLE_STOP];
            cap_reg <= pwdata[CTRL_CAP];
            data_filter_compare_count_reg <= pwdata[4:0];
            requested_operating_mode_reg <= pwdata[CTRL_REQUESTED_OPERATING_MODE_LO +: 3];
        end
    end

    // current mode trails the request by one clock
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            current_operating_mode_reg <= MODE_RESET_VAL;
        end else if (current_operating_mode_reg != requested_operating_mode_reg) begin
            current_operating_mode_reg <= requested_operating_mode_reg;
        end
    end
    assign mode_evt = (current_operating_mode_reg != requested_operating_mode_reg);

    // disable takes a few cycles to finish the current transaction
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            off_cnt_reg <= 4'h0;
            active_reg <= 1'b0;
        end else if (on_reg) begin
            off_cnt_reg <= DISABLE_DELAY;
            active_reg <= 1'b1;
        end else if (off_cnt_reg != 4'h0 || engine_busy) begin
            off_cnt_reg <= (off_cnt_reg != 4'h0) ? off_cnt_reg - 4'h1 : 4'h0;
            active_reg <= 1'b1;
        end else begin
            active_reg <= 1'b0;
        end
    end

    assign controller_run = active_reg &&
        !(idle_stop_reg && system_idle);
    assign data_filter_compare_count = data_filter_compare_count_reg;
    assign data_filter_valid = (data_filter_compare_count_reg <= DATA_FILTER_COMPARE_COUNT_MAX);

    // bit timing, writable only in configuration mode
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= 32'h00000000;
        end else if (wr && paddr == ADDR_CFG && current_operating_mode_reg == MODE_CONFIG) begin
            cfg_reg <= pwdata & CFG_MASK;
        end
    end

    assign seg1_tq = {1'b0, cfg_reg[CFG_SEG1_LO +: 3]} + 4'h1;
    assign seg2_free = {1'b0, cfg_reg[CFG_SEG2_LO +: 3]} + 4'h1;
    assign phase_segment_two_tq = cfg_reg[CFG_SEG2TS] ? seg2_free :
        ((seg1_tq > IPT_TQ) ? seg1_tq : IPT_TQ);
    assign phase_segment_one_tq = seg1_tq;
    assign propagation_tq = {1'b0, cfg_reg[CFG_PROPAGATION_SEGMENT_LENGTH_LO +: 3]} + 4'h1;
    assign sync_jump_tq = {1'b0, cfg_reg[CFG_SJW_LO +: 2]} + 3'h1;
    assign baud_prescaler = cfg_reg[5:0];
    // one sync quantum plus the three segments
    assign bit_time_tq = 6'h01 + {2'b00, propagation_tq} +
        {2'b00, phase_segment_one_tq} + {2'b00, phase_segment_two_tq};
    // three samples need room inside a quantum
    assign triple_sample = cfg_reg[CFG_SAM];

    // timestamp timer and prescaler
    // a timer write in the same cycle replaces the count, so no wrap
    assign ts_wrap = cap_reg && !tmr_wr && (precnt_reg == tspre_reg) &&
        (ts_reg == 16'hFFFF);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ts_reg <= 16'h0000;
            tspre_reg <= 16'h0000;
            precnt_reg <= 16'h0000;
        end else if (tmr_wr) begin
            ts_reg <= pwdata[31:16];
            tspre_reg <= pwdata[15:0];
            precnt_reg <= 16'h0000;
        end else if (cap_reg) begin
            if (precnt_reg == tspre_reg) begin
                precnt_reg <= 16'h0000;
                ts_reg <= ts_reg + 16'h0001;
            end else begin
                precnt_reg <= precnt_reg + 16'h0001;
            end
        end
    end
    assign timestamp_count = ts_reg;

    // sticky flags: write 1 clears, an event in the same cycle wins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            enables_reg <= 16'h0000;
        end else if (wr && paddr == ADDR_INT) begin
            enables_reg <= pwdata[31:16] & INT_FLAG_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= 16'h0000;
        end else begin
            if (wr && paddr == ADDR_INT) begin
                flags_reg <= flags_reg & ~(pwdata[15:0] & INT_STICKY_MASK);
            end
            if (wake_evt) begin
                flags_reg[INT_WAK] <= 1'b1;
            end
            if (bus_error_evt) begin
                flags_reg[INT_BUSERR] <= 1'b1;
            end
            if (system_error_evt || pslverr) begin
                flags_reg[INT_SYSERR] <= 1'b1;
            end
            if (|fifo_overflow_evt) begin
                flags_reg[INT_FIFO_OVERFLOW_BITS] <= 1'b1;
            end
            if (mode_evt) begin
                flags_reg[INT_MODE] <= 1'b1;
            end
            if (ts_wrap) begin
                flags_reg[INT_TMR] <= 1'b1;
            end
            flags_reg[INT_RB] <= rx_buffer_pending;
            flags_reg[INT_TB] <= tx_buffer_pending;
        end
    end

    // overflow bits clear only when the module is switched off
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ovf_reg <= 32'h00000000;
        end else if (!on_reg) begin
            ovf_reg <= fifo_overflow_evt;
        end else begin
            ovf_reg <= ovf_reg | fifo_overflow_evt;
        end
    end

    assign can_irq = |(flags_reg & enables_reg);

    always_comb begin
        rdata_next = 32'h00000000;
        case (paddr)
            ADDR_CTRL: begin
                rdata_next[CTRL_REQUESTED_OPERATING_MODE_LO +: 3] = requested_operating_mode_reg;
                rdata_next[CTRL_CURRENT_OPERATING_MODE_LO +: 3] = current_operating_mode_reg;
                rdata_next[CTRL_CAP] = cap_reg;
                rdata_next[CTRL_ON] = on_reg;
                rdata_next[CTRL_IDLE_STOP] = idle_stop_reg;
                rdata_next[CTRL_ACTIVE] = active_reg;
                rdata_next[4:0] = data_filter_compare_count_reg;
            end
            ADDR_CFG: begin
                rdata_next = cfg_reg;
            end
            ADDR_INT: begin
                rdata_next = {enables_reg, flags_reg};
            end
            ADDR_OVF: begin
                rdata_next = ovf_reg;
            end
            ADDR_TMR: begin
                rdata_next = {ts_reg, tspre_reg};
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= rdata_next;
        end
    end
endmodule

// ---- cbt_pkg.sv ----
// Purpose: constants for the can bit timing and status block
// Assumes: apb with 32-bit data, one word per register
// Notes: offsets are byte addresses
package cbt_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_INT = 8'h08;
    localparam logic [7:0] ADDR_OVF = 8'h0C;
    localparam logic [7:0] ADDR_TMR = 8'h10;
    // control word fields
    localparam int CTRL_ON = 15;
    localparam int CTRL_IDLE_STOP = 13;
    localparam int CTRL_ACTIVE = 11;
    localparam int CTRL_CAP = 20;
    localparam int CTRL_CURRENT_OPERATING_MODE_LO = 21;
    localparam int CTRL_REQUESTED_OPERATING_MODE_LO = 24;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] MODE_RESET_VAL = 3'h4;
    localparam logic [4:0] DATA_FILTER_COMPARE_COUNT_MAX = 5'h12;
    // config word fields
    localparam int CFG_WAKEUP_LINE_FILTER_ENABLE = 22;
    localparam int CFG_SEG2_LO = 16;
    localparam int CFG_SEG2TS = 15;
    localparam int CFG_SAM = 14;
    localparam int CFG_SEG1_LO = 11;
    localparam int CFG_PROPAGATION_SEGMENT_LENGTH_LO = 8;
    localparam int CFG_SJW_LO = 6;
    localparam logic [31:0] CFG_MASK = 32'h0047FFFF;
    // interrupt word: flags low, enables high
    localparam int INT_WAK = 14;
    localparam int INT_BUSERR = 13;
    localparam int INT_SYSERR = 12;
    localparam int INT_FIFO_OVERFLOW_BITS = 11;
    localparam int INT_MODE = 3;
    localparam int INT_TMR = 2;
    localparam int INT_RB = 1;
    localparam int INT_TB = 0;
    localparam logic [15:0] INT_FLAG_MASK = 16'h780F;
    localparam logic [15:0] INT_STICKY_MASK = 16'h780C;
    localparam logic [3:0] IPT_TQ = 4'h2;
    localparam int WAKE_FILT_LEN = 4;
    localparam logic [3:0] DISABLE_DELAY = 4'h8;
endpackage

// ---- cbt_checker.sv ----
// Purpose: port-level assertions for cbt_top
// Assumes: pready is always high, so an access phase is one cycle
// Notes: bound to cbt_top from the foot of this file
module cbt_checker
    import cbt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic [4:0] data_filter_compare_count,
    input wire logic data_filter_valid,
    input wire logic [3:0] phase_segment_one_tq,
    input wire logic [3:0] phase_segment_two_tq,
    input wire logic [3:0] propagation_tq,
    input wire logic [2:0] sync_jump_tq,
    input wire logic [5:0] bit_time_tq,
    input wire logic [15:0] timestamp_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic acc, mapped, tmr_wr;
    assign acc = psel && penable;
    assign mapped = paddr inside {ADDR_CTRL, ADDR_CFG, ADDR_INT, ADDR_OVF,
        ADDR_TMR};
    assign tmr_wr = acc && pwrite && (paddr == ADDR_TMR);
    AST_SEG_ONE: assert property (phase_segment_one_tq inside {[4'h1:4'h8]})
        else $error("phase one length out of range");
    AST_SEG_TWO: assert property (phase_segment_two_tq inside {[4'h1:4'h8]})
        else $error("phase two length out of range");
    AST_SJW: assert property (sync_jump_tq inside {[3'h1:3'h4]})
        else $error("jump width out of range");
    AST_BIT_TIME: assert property (bit_time_tq == 6'h01 + propagation_tq
        + phase_segment_one_tq + phase_segment_two_tq)
        else $error("bit time is not the sum of its segments");
    AST_DN_VALID: assert property (data_filter_valid ==
        (data_filter_compare_count <= DATA_FILTER_COMPARE_COUNT_MAX))
        else $error("filter count validity wrong");
    AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not flagged");
    AST_ERR_PHASE: assert property (pslverr |-> acc && !mapped)
        else $error("error response outside unmapped access");
    // a step larger than one would hide a skipped prescale period
    AST_TS_STEP: assert property ($changed(timestamp_count) &&
        !$past(tmr_wr) |-> timestamp_count == $past(timestamp_count) + 16'h0001)
        else $error("timestamp moved by other than one");
    COV_UNMAPPED: cover property (acc && !mapped);
    COV_TS: cover property ($changed(timestamp_count));
    COV_BAD_COUNT: cover property (!data_filter_valid);
endmodule
bind cbt_top cbt_checker cbt_checker_inst (.ref_clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pslverr, .data_filter_compare_count,
    .data_filter_valid, .phase_segment_one_tq, .phase_segment_two_tq,
    .propagation_tq, .sync_jump_tq, .bit_time_tq, .timestamp_count);

// ---- cbt_can_node.sv ----
// Purpose: far-side bus node that drives dominant bursts on can_rx
// Assumes: recessive is high and the line idles recessive
// Notes: burst length is set per request, so glitches can be made
module cbt_can_node (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [7:0] dom_len,
    output logic can_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_reg;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 8'h00;
        end else if (go) begin
            cnt_reg <= dom_len;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
    assign can_rx = (cnt_reg == 8'h00);
endmodule

// ---- cbt_tb_top.sv ----
// Purpose: self-checking bench for cbt_top
// Assumes: one-cycle access phase, current_operating_mode follows requested_operating_mode after one cycle
// Notes: timer checks start from the prescale count the timer write cleared, so phase is known
module cbt_tb_top;
    import cbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, pready, pslverr, err, controller_run, triple_sample;
    logic data_filter_valid, can_irq, can_rx;
    logic rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic system_idle = 1'h0, engine_busy = 1'h0, bus_error_evt = 1'h0;
    logic system_error_evt = 1'h0, go = 1'h0;
    logic rx_buffer_pending = 1'h0, tx_buffer_pending = 1'h0;
    logic [7:0] paddr = 8'h00, dom_len = 8'h00;
    logic [31:0] pwdata = 32'h0, fifo_overflow_evt = 32'h0, prdata, rd;
    logic [4:0] data_filter_compare_count;
    logic [3:0] phase_segment_one_tq, phase_segment_two_tq, propagation_tq;
    logic [2:0] sync_jump_tq;
    logic [5:0] baud_prescaler, bit_time_tq;
    logic [15:0] timestamp_count, t0;
    int n_mismatch = 0;
    int samples_checked = 0;
    cbt_top cbt_top_inst (.ref_clk, .rst_b, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .system_idle, .can_rx,
        .engine_busy, .bus_error_evt, .system_error_evt, .fifo_overflow_evt,
        .rx_buffer_pending, .tx_buffer_pending, .controller_run,
        .triple_sample, .data_filter_compare_count, .data_filter_valid,
        .phase_segment_one_tq, .phase_segment_two_tq, .propagation_tq,
        .sync_jump_tq, .baud_prescaler, .bit_time_tq, .timestamp_count,
        .wakeup_pulse(), .can_irq);
    cbt_can_node cbt_can_node_inst (.ref_clk, .rst_b, .go, .dom_len,
        .can_rx);
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_cfg();
        rdc(ADDR_CTRL, 32'h04800000);
        rdc(ADDR_CFG, 32'h00000000);
        wr(ADDR_CFG, 32'h0002D942);
        rdc(ADDR_CFG, 32'h0002D942);
        chk({phase_segment_one_tq, phase_segment_two_tq}, 8'h43);
        chk({propagation_tq, sync_jump_tq, baud_prescaler}, 13'h0482);
        chk({triple_sample, bit_time_tq}, 7'h4A);
        wr(ADDR_CFG, 32'h00001942);
        cyc(1);
        chk({triple_sample, phase_segment_two_tq}, 5'h04);
        // seg1 of one quantum: the processing time must win here
        wr(ADDR_CFG, 32'h00000742);
        cyc(1);
        chk(phase_segment_two_tq, 4'h2);
    endtask
    task automatic t_mode();
        wr(ADDR_INT, 32'h00080000);
        wr(ADDR_CTRL, 32'h00008000);
        cyc(2);
        rdc(ADDR_CTRL, 32'h00008800);
        rdc(ADDR_INT, 32'h00080008);
        chk(can_irq, 1'h1);
        wr(ADDR_CFG, 32'h0);
        rdc(ADDR_CFG, 32'h00000742);
        wr(ADDR_INT, 32'h00080008);
        rdc(ADDR_INT, 32'h00080000);
        chk(can_irq, 1'h0);
    endtask
    task automatic t_events();
        rdc(8'h20, 32'h0);
        chk(err, 1'h1);
        wr(ADDR_OVF, 32'hFFFFFFFF);
        bus_error_evt <= 1'h1;
        system_error_evt <= 1'h1;
        fifo_overflow_evt <= 32'h00000020;
        rx_buffer_pending <= 1'h1;
        tx_buffer_pending <= 1'h1;
        cyc(1);
        bus_error_evt <= 1'h0;
        system_error_evt <= 1'h0;
        fifo_overflow_evt <= 32'h0;
        rdc(ADDR_INT, 32'h00083803);
        rdc(ADDR_OVF, 32'h00000020);
        rx_buffer_pending <= 1'h0;
        tx_buffer_pending <= 1'h0;
        wr(ADDR_INT, 32'h00083800);
        rdc(ADDR_INT, 32'h00080000);
    endtask
    task automatic t_timer();
        wr(ADDR_TMR, 32'h00000003);
        wr(ADDR_CTRL, 32'h00108000);
        t0 = timestamp_count;
        cyc(33);
        chk(timestamp_count, t0 + 16'h0008);
        wr(ADDR_TMR, 32'h00050003);
        cyc(2);
        chk(timestamp_count, 16'h0005);
        rdc(ADDR_TMR, {timestamp_count, 16'h0003});
        wr(ADDR_CTRL, 32'h00008000);
        cyc(1);
        t0 = timestamp_count;
        cyc(10);
        chk(timestamp_count, t0);
        wr(ADDR_TMR, 32'hFFFF0000);
        wr(ADDR_CTRL, 32'h00108000);
        cyc(4);
        rdc(ADDR_INT, 32'h00080004);
    endtask
    task automatic t_idle();
        wr(ADDR_CTRL, 32'h0000A000);
        system_idle <= 1'h1;
        cyc(2);
        chk(controller_run, 1'h0);
        wr(ADDR_CTRL, 32'h00008000);
        cyc(2);
        chk(controller_run, 1'h1);
        system_idle <= 1'h0;
        engine_busy <= 1'h1;
        wr(ADDR_CTRL, 32'h0);
        cyc(12);
        rdc(ADDR_CTRL, 32'h00000800);
        engine_busy <= 1'h0;
        cyc(10);
        rdc(ADDR_CTRL, 32'h0);
    endtask
    task automatic t_filter_wake();
        logic [4:0] v [5] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1F};
        foreach (v[i]) begin
            wr(ADDR_CTRL, {27'h0200000, v[i]});
            cyc(1);
            chk({data_filter_compare_count, data_filter_valid},
                {v[i], v[i] <= 5'h12});
        end
        wr(ADDR_CFG, 32'h00400742);
        wr(ADDR_INT, 32'h0008FFFF);
        // a two-cycle glitch must not pass the wake-up line filter
        dom_len <= 8'h02;
        go <= 1'h1;
        cyc(1);
        go <= 1'h0;
        cyc(12);
        rdc(ADDR_INT, 32'h00080000);
        dom_len <= 8'h0C;
        go <= 1'h1;
        cyc(1);
        go <= 1'h0;
        cyc(20);
        rdc(ADDR_INT, 32'h00084000);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        cyc(20);
        rst_b <= 1'h1;
        t_cfg();
        t_mode();
        t_events();
        t_timer();
        t_idle();
        t_filter_wake();
        complete_run();
    end
    initial begin
        cyc(6000);
        n_mismatch++;
        complete_run();
    end
endmodule
